// ==== core/adsq_ctrl.sv ====
`timescale 1ns/1ps
module adsq_ctrl (
  // Clock and reset
  input  wire logic                 clk_i,
  input  wire logic                 rst_i,
  // Register port
  input  wire logic [2:0]           addr_i,
  input  wire logic [7:0]           wdata_i,
  input  wire logic                 wr_i,
  input  wire logic                 rd_i,
  output logic      [7:0]           rdata_o,
  // Converter data path
  input  wire logic [11:0]          conv_data_i,
  input  wire logic [4:0]           pin_analog_select_i,
  // Converter control
  output logic                      conv_power_o,
  output logic                      conv_sample_o,
  output logic                      conv_tick_o,
  output adsq_pkg::adsq_route_s     route_o,
  output logic      [4:0]           pin_function_off_o,
  output logic      [4:0]           pin_pullhigh_off_o,
  // Interrupt
  output logic                      irq_o
);

  logic [4:0]             ctrl_a_lo_q;   // Format and channel select
  logic                   start_q;
  logic                   enable_q;
  logic                   busy_q;
  adsq_pkg::adsq_ctrl_b_s ctrl_b_q;
  logic [7:0]             res_high_q;
  logic [7:0]             res_low_q;
  logic                   stat_q;
  logic                   mask_q;
  logic [4:0]             period_q;
  logic [7:0]             rdata_d;
  logic                   wr_a;
  logic                   wr_b;
  logic                   wr_stat;
  logic                   wr_mask;
  logic                   start_fall;
  logic                   tick;
  logic                   last_tick;
  logic                   done;
  logic                   fmt;
  logic [3:0]             chan;
  logic                   src_ext;
  logic                   src_sense;
  logic                   src_gnd;
  logic [7:0]             res_high_d;
  logic [7:0]             res_low_d;
  adsq_pkg::adsq_route_s  route_d;
  logic [4:0]             ext_onehot;

  // Write decode
  assign wr_a    = wr_i && (addr_i == {1'b0, adsq_pkg::ADDR_CTRL_A});
  assign wr_b    = wr_i && (addr_i == {1'b0, adsq_pkg::ADDR_CTRL_B});
  assign wr_stat = wr_i && (addr_i == adsq_pkg::ADDR_IRQ_STAT);
  assign wr_mask = wr_i && (addr_i == adsq_pkg::ADDR_IRQ_MASK);

  // A falling start bit while powered launches; a retrigger while busy is ignored
  assign start_fall = wr_a && start_q && !wdata_i[adsq_pkg::BIT_START]
                      && enable_q && !busy_q;
  assign last_tick  = tick && (period_q == adsq_pkg::TOTAL_LAST);
  assign done       = busy_q && last_tick;

  assign fmt  = ctrl_a_lo_q[adsq_pkg::BIT_FORMAT];
  assign chan = ctrl_a_lo_q[3:0];

  // Result layout with unused bits forced to zero
  assign res_high_d = fmt ? {4'h0, conv_data_i[11:8]} : conv_data_i[11:4];
  assign res_low_d  = fmt ? conv_data_i[7:0] : {conv_data_i[3:0], 4'h0};

  // Input source decode
  assign src_sense = (ctrl_b_q.input_source_select == adsq_pkg::SRC_SENSE);
  assign src_gnd   = (ctrl_b_q.input_source_select >= adsq_pkg::SRC_GND_LO)
                     && (ctrl_b_q.input_source_select <= adsq_pkg::SRC_GND_HI);
  assign src_ext   = !src_sense && !src_gnd;

  // Out-of-range channels leave the converter input floating
  assign ext_onehot = (src_ext && chan <= adsq_pkg::LAST_EXT_CHANNEL)
                      ? 5'(5'h01 << chan[2:0]) : 5'h00;

  assign route_d.ext_channel_onehot = ext_onehot;
  assign route_d.sense_connect      = src_sense;
  assign route_d.ground_connect     = src_gnd;
  assign route_d.ext_ref_connect    = (ctrl_b_q.reference_select != adsq_pkg::REF_SUPPLY);

  // Read mux; unmapped addresses read zero
  always_comb begin
    rdata_d = 8'h00;
    unique case (addr_i)
      {1'b0, adsq_pkg::ADDR_CTRL_A}:   rdata_d = {start_q, busy_q, enable_q, ctrl_a_lo_q};
      {1'b0, adsq_pkg::ADDR_CTRL_B}:   rdata_d = ctrl_b_q;
      {1'b0, adsq_pkg::ADDR_RES_LOW}:  rdata_d = res_low_q;
      {1'b0, adsq_pkg::ADDR_RES_HIGH}: rdata_d = res_high_q;
      adsq_pkg::ADDR_IRQ_STAT:         rdata_d = {7'h00, stat_q};
      adsq_pkg::ADDR_IRQ_MASK:         rdata_d = {7'h00, mask_q};
      default:                         rdata_d = 8'h00;
    endcase
  end

  adsq_clkdiv u_clkdiv (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .run_i  (busy_q && !done), // Stop at completion so no spare tick follows
    .sel_i  (ctrl_b_q.converter_clock_divider_select),
    .tick_o (tick)
  );

  // Control registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      {start_q, enable_q, ctrl_a_lo_q} <= {adsq_pkg::CTRL_A_RST[7], adsq_pkg::CTRL_A_RST[5],
                                           adsq_pkg::CTRL_A_RST[4:0]};
      ctrl_b_q <= adsq_pkg::CTRL_B_RST;
      mask_q   <= adsq_pkg::MASK_RST[0];
    end else begin
      if (wr_a) begin
        start_q     <= wdata_i[adsq_pkg::BIT_START];
        enable_q    <= wdata_i[adsq_pkg::BIT_ENABLE];
        ctrl_a_lo_q <= wdata_i[adsq_pkg::BIT_FORMAT:0];
      end
      if (wr_b) begin
        ctrl_b_q <= wdata_i;
      end
      if (wr_mask) begin
        mask_q <= wdata_i[0];
      end
    end
  end

  // Conversion sequencer: busy covers all sixteen converter periods
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      busy_q   <= 1'b0;
      period_q <= 5'h00;
    end else if (!enable_q) begin
      busy_q   <= 1'b0; // Power off aborts, results untouched
      period_q <= 5'h00;
    end else if (start_fall) begin
      busy_q   <= 1'b1;
      period_q <= 5'h00;
    end else if (done) begin
      busy_q   <= 1'b0;
      period_q <= 5'h00;
    end else if (busy_q && tick) begin
      period_q <= 5'(period_q + 5'h01);
    end
  end

  // Results load in the cycle busy clears, never while disabled
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      res_high_q <= 8'h00;
      res_low_q  <= 8'h00;
    end else if (done && enable_q) begin
      res_high_q <= res_high_d;
      res_low_q  <= res_low_d;
    end
  end

  // Sticky completion flag; a new completion beats a clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      stat_q <= 1'b0;
      irq_o  <= 1'b0;
    end else begin
      stat_q <= (done && enable_q) || (stat_q && !(wr_stat && wdata_i[0]));
      irq_o  <= stat_q && mask_q;
    end
  end

  // Registered outputs
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_o            <= 8'h00;
      conv_power_o       <= 1'b0;
      conv_sample_o      <= 1'b0;
      conv_tick_o        <= 1'b0;
      route_o            <= '0;
      pin_function_off_o <= 5'h00;
      pin_pullhigh_off_o <= 5'h00;
    end else begin
      rdata_o            <= rd_i ? rdata_d : 8'h00;
      conv_power_o       <= enable_q;
      conv_sample_o      <= busy_q && (period_q < 5'(adsq_pkg::SAMPLE_PERIODS));
      conv_tick_o        <= tick;
      route_o            <= route_d;
      pin_function_off_o <= pin_analog_select_i;
      pin_pullhigh_off_o <= pin_analog_select_i;
    end
  end

endmodule : adsq_ctrl

// ==== core/adsq_pkg.sv ====
package adsq_pkg;

  // Register offsets on the plain register port
  localparam logic [1:0] ADDR_CTRL_A   = 2'h0;
  localparam logic [1:0] ADDR_CTRL_B   = 2'h1;
  localparam logic [1:0] ADDR_RES_LOW  = 2'h2;
  localparam logic [1:0] ADDR_RES_HIGH = 2'h3;
  localparam int         ADDR_W        = 3;
  localparam logic [2:0] ADDR_IRQ_STAT = 3'h4;
  localparam logic [2:0] ADDR_IRQ_MASK = 3'h5;

  // Control register A field positions
  localparam int BIT_START  = 7;
  localparam int BIT_BUSY   = 6;
  localparam int BIT_ENABLE = 5;
  localparam int BIT_FORMAT = 4;

  // Reset values
  localparam logic [7:0] CTRL_A_RST = 8'h00;
  localparam logic [7:0] CTRL_B_RST = 8'h00;
  localparam logic [7:0] MASK_RST   = 8'h00;

  // Conversion timing in converter clock periods
  localparam int             SAMPLE_PERIODS  = 4;
  localparam int             CONVERT_PERIODS = 12;
  localparam logic [4:0]     TOTAL_PERIODS   = 5'(SAMPLE_PERIODS + CONVERT_PERIODS);
  localparam logic [4:0]     TOTAL_LAST      = 5'(SAMPLE_PERIODS + CONVERT_PERIODS - 1);

  // Channel and source limits
  localparam logic [3:0] LAST_EXT_CHANNEL = 4'h4;
  localparam logic [2:0] SRC_SENSE        = 3'h1;
  localparam logic [2:0] SRC_GND_LO       = 3'h2;
  localparam logic [2:0] SRC_GND_HI       = 3'h4;
  localparam logic [1:0] REF_SUPPLY       = 2'h1;

  // Control register B as a packed field group
  typedef struct packed {
    logic [2:0] input_source_select;
    logic [1:0] reference_select;
    logic [2:0] converter_clock_divider_select;
  } adsq_ctrl_b_s;

  // Analog routing outputs travelling together
  typedef struct packed {
    logic [4:0] ext_channel_onehot;
    logic       sense_connect;
    logic       ground_connect;
    logic       ext_ref_connect;
  } adsq_route_s;

endpackage : adsq_pkg

// ==== core/adsq_clkdiv.sv ====
`timescale 1ns/1ps
// Converter clock enable: one pulse every 2**sel system clocks
module adsq_clkdiv (
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // Control
  input  wire logic       run_i,
  input  wire logic [2:0] sel_i,
  // Converter clock tick
  output logic            tick_o
);

  logic [6:0] cnt_q;
  logic [6:0] cnt_d;
  logic [6:0] limit;
  logic       wrap;

  // Terminal count is divide ratio minus one
  assign limit = 7'((8'h01 << sel_i) - 8'h01);
  assign wrap  = (cnt_q >= limit);
  assign cnt_d = (!run_i || wrap) ? 7'h00 : 7'(cnt_q + 7'h01);

  // Restart on run so each conversion begins on a full period
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_q  <= 7'h00;
      tick_o <= 1'b0;
    end else begin
      cnt_q  <= cnt_d;
      tick_o <= run_i && wrap;
    end
  end

endmodule : adsq_clkdiv

// ==== testbench/adsq_ctrl_sva.sv ====
`timescale 1ns/1ps
module adsq_ctrl_sva (
  // Clock, reset, bus strobes and read data
  input wire logic                  clk_i,
  input wire logic                  rst_i,
  input wire logic                  wr_i,
  input wire logic                  rd_i,
  input wire logic [7:0]            rdata_o,
  // Pins and converter controls
  input wire logic [4:0]            pin_analog_select_i,
  input wire logic                  conv_power_o,
  input wire logic                  conv_sample_o,
  input wire adsq_pkg::adsq_route_s route_o,
  input wire logic [4:0]            pin_function_off_o,
  input wire logic [4:0]            pin_pullhigh_off_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // One edge out of reset, so $past sees live inputs
  sequence s_live;
    !rst_i ##1 1'b1;
  endsequence
  sequence s_no_read;
    !rd_i;
  endsequence
  chk_pin_func_off: assert property (s_live |-> pin_function_off_o == $past(pin_analog_select_i))
    else $error("pin function release wrong");
  chk_pin_pull_off: assert property (s_live |-> pin_pullhigh_off_o == $past(pin_analog_select_i))
    else $error("pull-high release wrong");
  chk_sense_no_ext: assert property (route_o.sense_connect |-> route_o.ext_channel_onehot == 5'h00)
    else $error("sense joined to external path");
  chk_ground_alone: assert property (route_o.ground_connect |-> !route_o.sense_connect)
    else $error("ground joined to sense path");
  chk_one_channel: assert property ($onehot0(route_o.ext_channel_onehot))
    else $error("several channels selected");
  chk_rdata_idle: assert property (s_no_read |=> rdata_o == 8'h00)
    else $error("read data without read");
  chk_sample_power: assert property (conv_sample_o |-> conv_power_o || $past(conv_power_o))
    else $error("sampling while powered off");
  // Routing only moves two edges after a register write
  chk_route_by_write: assert property ($changed(route_o) && !$past(rst_i, 2) |-> $past(wr_i, 2))
    else $error("routing changed without write");
endmodule : adsq_ctrl_sva

// ==== testbench/testbench.sv ====
`timescale 1ns/1ps
module testbench;
  logic                  clk_i = 1'b0;
  logic                  rst_i = 1'b1;
  logic [2:0]            addr_i = 3'h0;
  logic [7:0]            wdata_i = 8'h00;
  logic                  wr_i = 1'b0;
  logic                  rd_i = 1'b0;
  logic [11:0]           conv_data_i = 12'h000;
  logic [4:0]            pin_analog_select_i = 5'h00;
  logic [7:0]            rdata_o;
  logic                  conv_power_o, conv_sample_o, conv_tick_o, irq_o;
  adsq_pkg::adsq_route_s route_o;
  logic [4:0]            pin_function_off_o, pin_pullhigh_off_o;
  int                    miscompares = 0;
  int                    checks = 0;
  int                    cycles = 0;
  int                    ticks = 0;
  int                    samples = 0;
  logic [7:0]            v;
  always #2.5 clk_i = ~clk_i;
  adsq_ctrl u_adsq_ctrl (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .conv_data_i(conv_data_i),
    .pin_analog_select_i(pin_analog_select_i), .conv_power_o(conv_power_o),
    .conv_sample_o(conv_sample_o), .conv_tick_o(conv_tick_o), .route_o(route_o),
    .pin_function_off_o(pin_function_off_o), .pin_pullhigh_off_o(pin_pullhigh_off_o),
    .irq_o(irq_o));
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask : check
  // Strobe drops one edge later, so back-to-back calls never reassign it at once
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
    @(posedge clk_i);
  endtask : wr
  task automatic rdc(input logic [2:0] a, input logic [7:0] exp);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 v = rdata_o;
    check(v, exp);
    @(posedge clk_i);
  endtask : rdc
  task automatic regs_check();
    rdc(3'h0, 8'h00);
    rdc(3'h1, 8'h00);
    rdc(3'h5, 8'h00);
    rdc(3'h6, 8'h00);
    wr(3'h0, 8'h4f);
    rdc(3'h0, 8'h0f);
    wr(3'h1, 8'hff);
    rdc(3'h1, 8'hff);
  endtask : regs_check
  task automatic route_sweep();
    logic [2:0] src;
    logic [3:0] ch;
    logic [4:0] oh;
    for (int i = 0; i < 16; i++) begin
      src = 3'(i);
      ch = (i < 8) ? 4'(i % 5) : 4'(i);
      oh = ((src == 3'h0 || src >= 3'h5) && ch <= 4'h4) ? 5'(1 << ch) : 5'h00;
      wr(3'h0, {4'h2, ch});
      wr(3'h1, {src, 2'(i >> 1), 3'h0});
      pin_analog_select_i <= 5'(i);
      repeat (2) @(posedge clk_i);
      #1;
      check(route_o, {oh, src == 3'h1, src >= 3'h2 && src <= 3'h4, 2'(i >> 1) != 2'h1});
      check({3'h0, pin_pullhigh_off_o}, 8'(i[4:0]));
      check({3'h0, pin_function_off_o}, 8'(i[4:0]));
      @(posedge clk_i);
    end
  endtask : route_sweep
  // Start pulse, then poll busy and judge length, layout and interrupt
  task automatic convert(input logic f, input logic [2:0] div, input logic [11:0] d);
    int n;
    n = 0;
    conv_data_i <= d;
    wr(3'h1, {5'h00, div});
    wr(3'h0, {3'h5, f, 4'h0});
    repeat (4) @(posedge clk_i);
    rdc(3'h0, {3'h5, f, 4'h0});
    ticks = 0;
    samples = 0;
    wr(3'h0, {3'h1, f, 4'h0});
    do begin
      addr_i <= 3'h0;
      rd_i <= 1'b1;
      @(posedge clk_i);
      rd_i <= 1'b0;
      #1 n++;
      v = rdata_o;
      @(posedge clk_i);
    end while (v[6] === 1'b1 && n < 400);
    check(8'(n * 2 >= (16 << div) && n * 2 <= (16 << div) + 6), 8'h01);
    check(8'(ticks), 8'h10);
    check(8'(samples >= (4 << div) && samples <= (4 << div) + 1), 8'h01);
    rdc(3'h3, f ? {4'h0, d[11:8]} : d[11:4]);
    rdc(3'h2, f ? d[7:0] : {d[3:0], 4'h0});
    rdc(3'h4, 8'h01);
    check({7'h00, irq_o}, 8'h00);
    wr(3'h5, 8'h01);
    #1 check({7'h00, irq_o}, 8'h01);
    @(posedge clk_i);
    wr(3'h4, 8'h01);
    #1 check({7'h00, irq_o}, 8'h00);
    @(posedge clk_i);
    wr(3'h5, 8'h00);
  endtask : convert
  task automatic disabled_hold(input logic [11:0] d);
    wr(3'h0, 8'h10);
    conv_data_i <= ~d;
    wr(3'h0, 8'h90);
    wr(3'h0, 8'h10);
    repeat (40) @(posedge clk_i);
    check({7'h00, conv_power_o}, 8'h00);
    rdc(3'h0, 8'h10);
    rdc(3'h3, {4'h0, d[11:8]});
    rdc(3'h2, d[7:0]);
  endtask : disabled_hold
  task automatic report_and_stop();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : report_and_stop
  // Whole run is a few hundred cycles; the 8000-cycle limit stops a hang well above this
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (conv_tick_o === 1'b1) ticks++;
    if (conv_sample_o === 1'b1) samples++;
    if (cycles == 8000) begin
      miscompares++;
      report_and_stop();
    end
  end
  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    regs_check();
    route_sweep();
    convert(1'b0, 3'h0, 12'ha5c);
    convert(1'b1, 3'h3, 12'h3c7);
    disabled_hold(12'h3c7);
    report_and_stop();
  end
endmodule : testbench
bind adsq_ctrl adsq_ctrl_sva u_adsq_ctrl_sva (.clk_i(clk_i), .rst_i(rst_i), .wr_i(wr_i),
  .rd_i(rd_i), .rdata_o(rdata_o), .pin_analog_select_i(pin_analog_select_i),
  .conv_power_o(conv_power_o), .conv_sample_o(conv_sample_o), .route_o(route_o),
  .pin_function_off_o(pin_function_off_o), .pin_pullhigh_off_o(pin_pullhigh_off_o));
